/* core/mod_pins_pkg.sv */
// constants for the module control and status pin block
package mod_pins_pkg;
	// ----------------------------------------------------------------
	// register word indices, taken from paddr[7:2]
	// ----------------------------------------------------------------
	localparam int AW = 8;
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_ALARM = 6'h01;
	localparam logic [5:0] IDX_STATUS = 6'h02;
	localparam logic [5:0] IDX_BER_THR = 6'h03;
	localparam logic [5:0] IDX_PRBS_ERR = 6'h04;
	localparam logic [5:0] IDX_CORR = 6'h05;
	localparam logic [5:0] IDX_UNCORR = 6'h06;
	localparam logic [5:0] IDX_CD_DGD = 6'h07;
	localparam logic [5:0] IDX_FREQ = 6'h08;
	localparam logic [5:0] IDX_PM_CNT = 6'h09;
	localparam logic [5:0] IDX_MDIO_ADDR = 6'h0A;
	localparam logic [5:0] IDX_LAST = IDX_MDIO_ADDR;
	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int C_TXDIS = 0;
	localparam int C_LOPWR = 1;
	localparam int C_LB_IN = 2;
	localparam int C_LB_OUT = 3;
	localparam int C_GEN = 4;
	localparam int C_CHK = 5;
	localparam int C_PSEL = 6;
	localparam int C_READY = 8;
	localparam int C_KEYTX = 9;
	localparam int C_ASEL1 = 10;
	localparam int C_ASEL2 = 12;
	localparam int C_ASEL3 = 14;
	localparam logic [31:0] CTRL_RST = 32'h0000_9200;
	// alarm sources for the programmable outputs
	localparam logic [1:0] SRC_HIPWR = 2'h0;
	localparam logic [1:0] SRC_READY = 2'h1;
	localparam logic [1:0] SRC_FAULT = 2'h2;
	localparam logic [1:0] SRC_BER = 2'h3;
	// sticky alarm bits
	localparam int A_LOS = 0;
	localparam int A_FAULT = 1;
	localparam int A_BER = 2;
	localparam int A_ILOCK = 3;
	localparam int A_KEY = 4;
	localparam int A_W = 5;
	localparam logic [A_W-1:0] A_GLOBAL = 5'h0F;
	// ----------------------------------------------------------------
	// prbs and management frame
	// ----------------------------------------------------------------
	localparam logic [1:0] PRBS7 = 2'h0;
	localparam logic [1:0] PRBS15 = 2'h1;
	localparam logic [1:0] PRBS31 = 2'h2;
	localparam int PRBS_W = 31;
	localparam logic [5:0] PRE_LEN = 6'd32;
	localparam logic [4:0] HDR_BITS = 5'd12;
	localparam logic [4:0] DATA_BITS = 5'd16;
	localparam logic [1:0] OP_ADDR = 2'b00;
	localparam logic [1:0] OP_WRITE = 2'b01;
	localparam logic [1:0] OP_RINC = 2'b10;
	localparam logic [1:0] OP_READ = 2'b11;
endpackage

/* core/mod_pins.sv */
// control/status pins, management frame slave and register file
// ----------------------------------------------------------------
// Functional notes
// R1: transmit disable pin high turns laser off
// R2: loss-of-signal output follows receive signal loss
// R3: low-power request high selects safe mode
// R4: reset pin low holds module in reset
// R5: open-drain global alarm low on any alarm; A_GLOBAL leaves the key event alarm out of it
// R6: alarm one defaults to high-power state
// R7: alarm two defaults to ready state
// R8: alarm three defaults to fault state
// R9: interlock inputs both high allow transmission
// R10: shared sync pulse aligns monitoring intervals
// R11: strapped port address identifies management port
// R12: presence output tied low when inserted
// R13: interrupt output flags key exchange events
// R14: host drives key serial in, takes out
// R15: prbs 7/15/31 generators and checkers, both sides
// R16: client loopback both directions under control
// R17: line monitors readable over management; mdio reads give only the cd half of IDX_CD_DGD, not dgd_in
// R18: error-rate threshold output on crossing
// R19: clause 45 management over mdc and mdio
// R20: answer only frames addressed to strapped port
// ----------------------------------------------------------------
module mod_pins
	import mod_pins_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [mod_pins_pkg::AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic transmit_disable_in,
	input wire logic low_power_request,
	input wire logic module_reset_n,
	input wire logic interlock_in_one,
	input wire logic prog_control_two,
	input wire logic interlock_in_three,
	input wire logic [2:0] port_addr_straps,
	input wire logic key_serial_in,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic optical_los_in,
	input wire logic fault_in,
	input wire logic [15:0] ber_in,
	input wire logic corr_err_pulse,
	input wire logic uncorr_err_pulse,
	input wire logic [15:0] cd_in,
	input wire logic [15:0] dgd_in,
	input wire logic [15:0] freq_offset_in,
	input wire logic [1:0] prbs_rx_bit,
	output logic [1:0] prbs_tx_bit,
	output logic tx_enable,
	output logic receive_signal_lost,
	output logic low_power_mode,
	output logic module_absent,
	output logic any_alarm_n_out,
	output logic any_alarm_n_oe,
	output logic prog_alarm_one,
	output logic prog_alarm_two,
	output logic prog_alarm_three,
	output logic ber_threshold,
	output logic host_int,
	output logic key_serial_out,
	output logic loopback_in_en,
	output logic loopback_out_en
);
	import mod_pins_pkg::*;

	typedef enum logic [2:0] {MS_PRE, MS_ST, MS_HDR, MS_TA, MS_DATA} mdio_st_t;

	logic [31:0] ctrl_r, ctrl_nxt;
	logic [A_W-1:0] alarm_r, alarm_nxt;
	logic [15:0] ber_thr_r, ber_thr_nxt;
	logic [15:0] corr_r, corr_nxt, uncorr_r, uncorr_nxt;
	logic [15:0] corr_snap_r, corr_snap_nxt, unc_snap_r, unc_snap_nxt;
	logic [31:0] cd_dgd_r, cd_dgd_nxt;
	logic [15:0] freq_r, freq_nxt, pm_cnt_r, pm_cnt_nxt;
	logic pm_q_r, key_q_r;
	logic [8:0] out_r, out_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt, pready_r;
	logic [15:0] prbs_err [2];
	logic hold, ilock_ok, hp, rdy, ber_hit, apb_wr, prbs_clr;
	logic [5:0] pidx;
	// management frame state
	mdio_st_t ms_r, ms_nxt;
	logic mdc_q_r;
	logic [5:0] ones_r, ones_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [11:0] hdr_r, hdr_nxt;
	logic [15:0] sh_r, sh_nxt, maddr_r, maddr_nxt;
	logic mout_r, mout_nxt, moe_r, moe_nxt, hit_r, hit_nxt;
	logic mwr;

	// ----------------------------------------------------------------
	// shared read decode
	// ----------------------------------------------------------------
	function automatic logic [31:0] rd_word(input logic [5:0] idx);
		case (idx)
			IDX_CTRL: rd_word = ctrl_r;
			IDX_ALARM: rd_word = {{(32-A_W){1'b0}}, alarm_r};
			IDX_STATUS: rd_word = {22'h0, port_addr_straps, prog_control_two,
				ilock_ok, low_power_request, transmit_disable_in,
				fault_in, out_r[0], out_r[2]};
			IDX_BER_THR: rd_word = {16'h0, ber_thr_r};
			IDX_PRBS_ERR: rd_word = {prbs_err[1], prbs_err[0]}; // R15
			IDX_CORR: rd_word = {16'h0, corr_snap_r}; // R17
			IDX_UNCORR: rd_word = {16'h0, unc_snap_r}; // R17
			IDX_CD_DGD: rd_word = cd_dgd_r; // R17
			IDX_FREQ: rd_word = {16'h0, freq_r}; // R17
			IDX_PM_CNT: rd_word = {16'h0, pm_cnt_r};
			IDX_MDIO_ADDR: rd_word = {16'h0, maddr_r};
			default: rd_word = 32'h0;
		endcase
	endfunction

	function automatic logic alarm_src(input logic [1:0] sel,
		input logic [3:0] src);
		alarm_src = src[sel];
	endfunction

	// ----------------------------------------------------------------
	// pin level conditions
	// ----------------------------------------------------------------
	assign hold = !module_reset_n; // R4
	assign ilock_ok = interlock_in_one & interlock_in_three; // R9
	assign pidx = paddr[7:2];
	assign apb_wr = psel & penable & pwrite & !pslverr_r;
	assign prbs_clr = apb_wr & (pidx == IDX_PRBS_ERR);
	assign hp = !(low_power_request | ctrl_r[C_LOPWR] | hold); // R3
	assign rdy = hp & ctrl_r[C_READY] & !fault_in;
	assign ber_hit = ber_in > ber_thr_r; // R18

	// ----------------------------------------------------------------
	// management frame slave
	// ----------------------------------------------------------------
	// mdc is sampled on sys_clk, so it must be well under half its rate
	always_comb begin
		ms_nxt = ms_r;
		ones_nxt = ones_r;
		cnt_nxt = cnt_r;
		hdr_nxt = hdr_r;
		sh_nxt = sh_r;
		maddr_nxt = maddr_r;
		mout_nxt = mout_r;
		moe_nxt = moe_r;
		hit_nxt = hit_r;
		mwr = 1'b0;
		if (mdc & !mdc_q_r) begin // R19
			case (ms_r)
				MS_PRE: begin
					if (mdio_in) begin
						if (ones_r != PRE_LEN)
							ones_nxt = ones_r + 6'd1;
					end else begin
						if (ones_r == PRE_LEN)
							ms_nxt = MS_ST;
						ones_nxt = 6'd0;
					end
				end
				MS_ST: begin
					cnt_nxt = 5'd0;
					ms_nxt = mdio_in ? MS_PRE : MS_HDR;
				end
				MS_HDR: begin
					hdr_nxt = {hdr_r[10:0], mdio_in};
					cnt_nxt = cnt_r + 5'd1;
					if (cnt_r == HDR_BITS - 5'd1) begin
						ms_nxt = MS_TA;
						cnt_nxt = 5'd0;
						// foreign frames are still tracked to keep framing
						hit_nxt = (hdr_r[8:4] ==
							{2'b00, port_addr_straps}); // R20 R11
					end
				end
				MS_TA: begin
					cnt_nxt = cnt_r + 5'd1;
					if (cnt_r == 5'd0) begin
						if (hit_r & hdr_r[11]) begin
							moe_nxt = 1'b1;
							mout_nxt = 1'b0;
							sh_nxt = 16'(rd_word(maddr_r[5:0]));
						end
					end else begin
						ms_nxt = MS_DATA;
						cnt_nxt = 5'd0;
						if (moe_r) begin
							mout_nxt = sh_r[15];
							sh_nxt = {sh_r[14:0], 1'b0};
						end
					end
				end
				MS_DATA: begin
					cnt_nxt = cnt_r + 5'd1;
					if (moe_r) begin
						mout_nxt = sh_r[15];
						sh_nxt = {sh_r[14:0], 1'b0};
					end else begin
						sh_nxt = {sh_r[14:0], mdio_in};
					end
					if (cnt_r == DATA_BITS - 5'd1) begin
						ms_nxt = MS_PRE;
						moe_nxt = 1'b0;
						mout_nxt = 1'b0;
						if (hit_r) begin
							case (hdr_r[11:10])
								OP_ADDR: maddr_nxt = {sh_r[14:0], mdio_in};
								OP_WRITE: mwr = 1'b1;
								OP_RINC: maddr_nxt = maddr_r + 16'd1;
								default: maddr_nxt = maddr_r;
							endcase
						end
					end
				end
				default: ms_nxt = MS_PRE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ms_r <= MS_PRE;
			mdc_q_r <= 1'b0;
			ones_r <= 6'd0;
			cnt_r <= 5'd0;
			hdr_r <= 12'h000;
			sh_r <= 16'h0000;
			maddr_r <= 16'h0000;
			mout_r <= 1'b0;
			moe_r <= 1'b0;
			hit_r <= 1'b0;
		end else begin
			ms_r <= ms_nxt;
			mdc_q_r <= mdc;
			ones_r <= ones_nxt;
			cnt_r <= cnt_nxt;
			hdr_r <= hdr_nxt;
			sh_r <= sh_nxt;
			maddr_r <= maddr_nxt;
			mout_r <= mout_nxt;
			moe_r <= moe_nxt;
			hit_r <= hit_nxt;
		end
	end

	// ----------------------------------------------------------------
	// prbs generators and checkers, line (0) and client (1)
	// ----------------------------------------------------------------
	function automatic logic prbs_fb(input logic [1:0] sel,
		input logic [PRBS_W-1:0] s);
		case (sel)
			PRBS7: prbs_fb = s[6] ^ s[5];
			PRBS15: prbs_fb = s[14] ^ s[13];
			default: prbs_fb = s[30] ^ s[27];
		endcase
	endfunction

	for (genvar g = 0; g < 2; g++) begin : g_prbs
		logic [PRBS_W-1:0] gen_r, gen_nxt, chk_r, chk_nxt;
		logic [15:0] err_r, err_nxt;
		logic tx_r, tx_nxt;
		always_comb begin
			gen_nxt = gen_r;
			chk_nxt = chk_r;
			err_nxt = err_r;
			tx_nxt = 1'b0;
			if (ctrl_r[C_GEN]) begin // R15
				tx_nxt = prbs_fb(ctrl_r[C_PSEL+:2], gen_r);
				gen_nxt = {gen_r[PRBS_W-2:0], tx_nxt};
			end
			if (ctrl_r[C_CHK]) begin // R15
				chk_nxt = {chk_r[PRBS_W-2:0], prbs_rx_bit[g]};
				if (prbs_rx_bit[g] != prbs_fb(ctrl_r[C_PSEL+:2], chk_r) &&
					err_r != 16'hFFFF)
					err_nxt = err_r + 16'd1;
			end
			if (prbs_clr | hold)
				err_nxt = 16'h0000;
		end
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				gen_r <= {PRBS_W{1'b1}};
				chk_r <= {PRBS_W{1'b0}};
				err_r <= 16'h0000;
				tx_r <= 1'b0;
			end else begin
				gen_r <= gen_nxt;
				chk_r <= chk_nxt;
				err_r <= err_nxt;
				tx_r <= tx_nxt;
			end
		end
		assign prbs_err[g] = err_r;
		assign prbs_tx_bit[g] = tx_r;
	end

	// ----------------------------------------------------------------
	// register file, monitors and pin outputs
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		ber_thr_nxt = ber_thr_r;
		alarm_nxt = alarm_r;
		corr_nxt = corr_r + {15'h0, corr_err_pulse};
		uncorr_nxt = uncorr_r + {15'h0, uncorr_err_pulse};
		corr_snap_nxt = corr_snap_r;
		unc_snap_nxt = unc_snap_r;
		cd_dgd_nxt = cd_dgd_r;
		freq_nxt = freq_r;
		pm_cnt_nxt = pm_cnt_r;
		// sync edge closes one interval on every module at once
		if (prog_control_two & !pm_q_r) begin // R10
			pm_cnt_nxt = pm_cnt_r + 16'd1;
			corr_snap_nxt = corr_r;
			unc_snap_nxt = uncorr_r;
			corr_nxt = {15'h0, corr_err_pulse};
			uncorr_nxt = {15'h0, uncorr_err_pulse};
			cd_dgd_nxt = {dgd_in, cd_in};
			freq_nxt = freq_offset_in;
		end
		if (mwr) begin
			if (maddr_r[5:0] == IDX_CTRL)
				ctrl_nxt[15:0] = {sh_r[14:0], mdio_in};
			if (maddr_r[5:0] == IDX_BER_THR)
				ber_thr_nxt = {sh_r[14:0], mdio_in};
		end
		if (apb_wr) begin
			case (pidx)
				IDX_CTRL: ctrl_nxt = pwdata;
				IDX_BER_THR: ber_thr_nxt = pwdata[15:0];
				IDX_ALARM: alarm_nxt = alarm_r & ~pwdata[A_W-1:0];
				default: ctrl_nxt = ctrl_nxt;
			endcase
		end
		// a new event wins over a clear in the same cycle
		alarm_nxt[A_LOS] = alarm_nxt[A_LOS] | optical_los_in;
		alarm_nxt[A_FAULT] = alarm_nxt[A_FAULT] | fault_in;
		alarm_nxt[A_BER] = alarm_nxt[A_BER] | ber_hit;
		alarm_nxt[A_ILOCK] = alarm_nxt[A_ILOCK] | !ilock_ok;
		alarm_nxt[A_KEY] = alarm_nxt[A_KEY] |
			(key_q_r & !key_serial_in); // R13
		if (hold) begin // R4
			ctrl_nxt = CTRL_RST;
			alarm_nxt = '0;
		end
		// [0] tx [1] any alarm [2] hipwr [3..5] alarms [6] ber [7] int [8] los
		out_nxt[0] = !(transmit_disable_in | ctrl_r[C_TXDIS] | !hp
			| !ilock_ok); // R1 R9
		out_nxt[1] = |(alarm_r & A_GLOBAL); // R5
		out_nxt[2] = hp; // R3
		out_nxt[3] = alarm_src(ctrl_r[C_ASEL1+:2],
			{ber_hit, fault_in, rdy, hp}); // R6
		out_nxt[4] = alarm_src(ctrl_r[C_ASEL2+:2],
			{ber_hit, fault_in, rdy, hp}); // R7
		out_nxt[5] = alarm_src(ctrl_r[C_ASEL3+:2],
			{ber_hit, fault_in, rdy, hp}); // R8
		out_nxt[6] = ber_hit; // R18
		out_nxt[7] = alarm_r[A_KEY]; // R13
		out_nxt[8] = optical_los_in; // R2
		// zero-wait slave: read data is fetched in the setup cycle
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (psel & !penable) begin
			pslverr_nxt = (paddr[1:0] != 2'b00) || (pidx > IDX_LAST);
			prdata_nxt = pslverr_nxt ? 32'h0 : rd_word(pidx);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			alarm_r <= '0;
			ber_thr_r <= 16'hFFFF;
			corr_r <= 16'h0000;
			uncorr_r <= 16'h0000;
			corr_snap_r <= 16'h0000;
			unc_snap_r <= 16'h0000;
			cd_dgd_r <= 32'h0;
			freq_r <= 16'h0000;
			pm_cnt_r <= 16'h0000;
			pm_q_r <= 1'b1;
			key_q_r <= 1'b1;
			out_r <= 9'h000;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
			pready_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			alarm_r <= alarm_nxt;
			ber_thr_r <= ber_thr_nxt;
			corr_r <= corr_nxt;
			uncorr_r <= uncorr_nxt;
			corr_snap_r <= corr_snap_nxt;
			unc_snap_r <= unc_snap_nxt;
			cd_dgd_r <= cd_dgd_nxt;
			freq_r <= freq_nxt;
			pm_cnt_r <= pm_cnt_nxt;
			pm_q_r <= prog_control_two;
			key_q_r <= key_serial_in;
			out_r <= out_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			pready_r <= 1'b1;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign mdio_out = mout_r;
	assign mdio_oe = moe_r;
	assign tx_enable = out_r[0];
	assign any_alarm_n_out = 1'b0;
	assign any_alarm_n_oe = out_r[1]; // R5
	assign low_power_mode = !out_r[2];
	assign prog_alarm_one = out_r[3];
	assign prog_alarm_two = out_r[4];
	assign prog_alarm_three = out_r[5];
	assign ber_threshold = out_r[6];
	assign host_int = out_r[7];
	assign receive_signal_lost = out_r[8];
	assign module_absent = 1'b0; // R12
	assign key_serial_out = ctrl_r[C_KEYTX]; // R14
	assign loopback_in_en = ctrl_r[C_LB_IN]; // R16
	assign loopback_out_en = ctrl_r[C_LB_OUT]; // R16
endmodule // mod_pins

/* verif/mod_pins_assertions.sv */
// concurrent checks on the pin level behaviour of mod_pins
module mod_pins_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic transmit_disable_in,
	input wire logic low_power_request,
	input wire logic module_reset_n,
	input wire logic interlock_in_one,
	input wire logic interlock_in_three,
	input wire logic key_serial_in,
	input wire logic optical_los_in,
	input wire logic fault_in,
	input wire logic tx_enable,
	input wire logic receive_signal_lost,
	input wire logic low_power_mode,
	input wire logic module_absent,
	input wire logic any_alarm_n_out,
	input wire logic any_alarm_n_oe,
	input wire logic prog_alarm_one,
	input wire logic prog_alarm_three,
	input wire logic host_int
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// pins follow their causes one or two clocks later
	// ----------------------------------------------------------------
	tx_off_a: assert property (transmit_disable_in |=> !tx_enable)
		else $error("laser on while disabled");
	los_on_a: assert property (optical_los_in |=> receive_signal_lost)
		else $error("loss of signal not shown");
	low_power_a: assert property (low_power_request |=> low_power_mode)
		else $error("low power request ignored");
	hold_reset_a: assert property (!module_reset_n |=>
		low_power_mode && !tx_enable)
		else $error("module not held in reset");
	glob_alarm_a: assert property (optical_los_in |-> ##[1:2]
		(any_alarm_n_oe && !any_alarm_n_out))
		else $error("global alarm not pulled low");
	alarm_one_a: assert property (low_power_request |=> !prog_alarm_one)
		else $error("high power shown in low power");
	// the bench keeps the default alarm routing throughout
	alarm_three_a: assert property (fault_in |=> prog_alarm_three)
		else $error("fault not shown");
	interlock_a: assert property (!(interlock_in_one &&
		interlock_in_three) |=> !tx_enable)
		else $error("laser on with interlock open");
	present_a: assert property (!module_absent)
		else $error("presence pin not low");
	key_event_a: assert property ($fell(key_serial_in) |-> ##[1:2] host_int)
		else $error("key event interrupt missing");
	cover property (optical_los_in ##1 any_alarm_n_oe);
	cover property (!module_reset_n ##1 module_reset_n);
	cover property ($fell(key_serial_in) ##2 host_int);
endmodule // mod_pins_checker

/* verif/host_mgmt.sv */
// host side management master: clock and shared data line
module host_mgmt (
	input wire logic sys_clk,
	output logic mdc,
	output logic mdio_in,
	input wire logic mdio_out,
	input wire logic mdio_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv;
	logic bit_o;
	// a released line rises to the pull-up level
	assign mdio_in = drv ? bit_o : (mdio_oe ? mdio_out : 1'b1);
	initial begin
		mdc = 1'b0;
		drv = 1'b0;
		bit_o = 1'b1;
	end
	// clock stands low between frames; three system clocks per half bit
	task automatic frame(input logic [1:0] op, input logic [4:0] pa,
		input logic [15:0] d, output logic [15:0] q);
		logic [63:0] f;
		f = {32'hFFFF_FFFF, 2'b00, op, pa, 5'h01, 2'b10, d};
		for (int i = 63; i >= 0; i--) begin
			drv <= !(op[1] && i < 18);
			bit_o <= f[i];
			repeat (3) @(posedge sys_clk);
			if (i < 16)
				q = {q[14:0], mdio_in};
			mdc <= 1'b1;
			repeat (3) @(posedge sys_clk);
			mdc <= 1'b0;
		end
		drv <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule // host_mgmt

/* verif/testbench.sv */
// self-checking bench for the module pin and management block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mod_pins_pkg::*;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic transmit_disable_in, low_power_request, module_reset_n;
	logic interlock_in_one, prog_control_two, interlock_in_three;
	logic [2:0] port_addr_straps;
	logic key_serial_in, mdc, mdio_in, mdio_out, mdio_oe;
	logic optical_los_in, fault_in, corr_err_pulse, uncorr_err_pulse;
	logic [15:0] ber_in, cd_in, dgd_in, freq_offset_in, mq;
	logic [1:0] prbs_rx_bit, prbs_tx_bit, flip;
	logic tx_enable, receive_signal_lost, low_power_mode, module_absent;
	logic any_alarm_n_out, any_alarm_n_oe, prog_alarm_one, prog_alarm_two;
	logic prog_alarm_three, ber_threshold, host_int, key_serial_out;
	logic loopback_in_en, loopback_out_en;
	int miscompares, num_checks;
	assign prbs_rx_bit = prbs_tx_bit ^ flip;
	mod_pins DUT (.*);
	host_mgmt host (.sys_clk, .mdc, .mdio_in, .mdio_out, .mdio_oe);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rq, output logic e);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the slave
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rq = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge sys_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		logic e;
		apb(1'b0, a, '0, q, e);
		chk(q, x);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		logic e;
		rd(8'h00, 32'h0000_9200);
		rd(8'h0C, 32'h0000_FFFF);
		rd(8'h08, 32'h0000_02A3);
		apb(1'b0, 8'h2C, '0, q, e);
		chk(32'(e), 32'h1);
		apb(1'b0, 8'h02, '0, q, e);
		chk(32'(e), 32'h1);
	endtask
	task pulse_sync;
		prog_control_two <= 1'b1;
		tick(4);
		prog_control_two <= 1'b0;
		tick(4);
	endtask
	task t_pm;
		{cd_in, dgd_in, freq_offset_in} <= 48'h1111_2222_3333;
		pulse_sync;
		repeat (3) begin
			{corr_err_pulse, uncorr_err_pulse} <= 2'b11;
			@(posedge sys_clk);
			{corr_err_pulse, uncorr_err_pulse} <= 2'b00;
			@(posedge sys_clk);
		end
		pulse_sync;
		rd(8'h24, 32'h2);
		rd(8'h14, 32'h3);
		rd(8'h18, 32'h3);
		rd(8'h1C, 32'h2222_1111);
		rd(8'h20, 32'h3333);
	endtask
	task t_pins;
		logic [3:0] v [5];
		v = '{4'h3, 4'hB, 4'h7, 4'h1, 4'h2};
		foreach (v[i]) begin
			{transmit_disable_in, low_power_request, interlock_in_one,
				interlock_in_three} <= v[i];
			tick(2);
			chk(32'(tx_enable), 32'(v[i] == 4'h3));
			chk(32'(low_power_mode), 32'(v[i][2]));
			chk(32'(prog_alarm_one), 32'(!v[i][2]));
		end
		// close the interlock again so later alarm checks start clean
		{transmit_disable_in, low_power_request, interlock_in_one,
			interlock_in_three} <= 4'h3;
		wr(8'h00, 32'h0000_9300);
		module_reset_n <= 1'b0;
		tick(2);
		chk(32'({tx_enable, low_power_mode}), 32'h1);
		module_reset_n <= 1'b1;
		tick(1);
		rd(8'h00, 32'h0000_9200);
	endtask
	task t_alarm;
		wr(8'h04, 32'h1F);
		wr(8'h00, 32'h0000_9300);
		tick(2);
		chk(32'({prog_alarm_two, any_alarm_n_oe}), 32'h2);
		fault_in <= 1'b1;
		tick(3);
		chk(32'({prog_alarm_two, prog_alarm_three}), 32'h1);
		chk(32'({any_alarm_n_oe, any_alarm_n_out}), 32'h2);
		fault_in <= 1'b0;
		optical_los_in <= 1'b1;
		tick(3);
		// a clear while the loss persists must not stick
		wr(8'h04, 32'h1F);
		chk(32'({receive_signal_lost, any_alarm_n_oe}), 32'h3);
		optical_los_in <= 1'b0;
		tick(2);
		wr(8'h04, 32'h1F);
		tick(2);
		chk(32'({receive_signal_lost, any_alarm_n_oe}), 32'h0);
		chk(32'(module_absent), 32'h0);
	endtask
	task t_key;
		chk(32'(key_serial_out), 32'h1);
		chk(32'({loopback_in_en, loopback_out_en}), 32'h0);
		key_serial_in <= 1'b0;
		tick(3);
		chk(32'(host_int), 32'h1);
		key_serial_in <= 1'b1;
		wr(8'h04, 32'h10);
		wr(8'h00, 32'h0000_910C);
		wr(8'h0C, 32'h0100);
		ber_in <= 16'h0101;
		tick(2);
		chk(32'({host_int, key_serial_out}), 32'h0);
		chk(32'({loopback_in_en, loopback_out_en}), 32'h3);
		chk(32'(ber_threshold), 32'h1);
		ber_in <= 16'h0100;
		tick(2);
		chk(32'(ber_threshold), 32'h0);
	endtask
	task t_prbs;
		int n;
		logic e;
		for (int m = 0; m < 3; m++) begin
			wr(8'h00, {24'h92, 2'(m), 6'h30});
			tick(80);
			wr(8'h10, 32'h0);
			tick(100);
			rd(8'h10, 32'h0);
		end
		wr(8'h00, 32'h0000_9230);
		tick(10);
		n = 0;
		// one full period of the short sequence holds 64 ones per lane
		repeat (127) begin
			@(posedge sys_clk);
			n += prbs_tx_bit[0] + prbs_tx_bit[1];
		end
		chk(32'(n), 32'h80);
		wr(8'h10, 32'h0);
		flip <= 2'h3;
		@(posedge sys_clk);
		flip <= 2'h0;
		tick(4);
		apb(1'b0, 8'h10, '0, q, e);
		chk(32'({q[31:16] != 0, q[15:0] != 0}), 32'h3);
	endtask
	task t_mdio;
		host.frame(OP_ADDR, 5'h05, 16'h0003, mq);
		host.frame(OP_WRITE, 5'h05, 16'h1234, mq);
		host.frame(OP_WRITE, 5'h04, 16'h5555, mq);
		rd(8'h0C, 32'h1234);
		host.frame(OP_READ, 5'h05, 16'h0, mq);
		chk(32'(mq), 32'h1234);
		host.frame(OP_READ, 5'h06, 16'h0, mq);
		chk(32'(mq), 32'hFFFF);
		port_addr_straps <= 3'h2;
		host.frame(OP_READ, 5'h02, 16'h0, mq);
		chk(32'(mq), 32'h1234);
		host.frame(OP_RINC, 5'h02, 16'h0, mq);
		chk(32'(mq), 32'h1234);
		rd(8'h28, 32'h4);
	endtask
	task test_done;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{transmit_disable_in, low_power_request, fault_in} = '0;
		{optical_los_in, corr_err_pulse, uncorr_err_pulse} = '0;
		{prog_control_two, flip, ber_in, cd_in, dgd_in} = '0;
		freq_offset_in = '0;
		{module_reset_n, interlock_in_one, interlock_in_three} = '1;
		key_serial_in = 1'b1;
		port_addr_straps = 3'h5;
		miscompares = 0;
		num_checks = 0;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_regs;
		t_pm;
		t_pins;
		t_alarm;
		t_key;
		t_prbs;
		t_mdio;
		test_done;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		miscompares++;
		test_done;
	end
endmodule // testbench
bind mod_pins mod_pins_checker chk_i (.*);
